// *** inc/evcnt_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: Definitions only
`ifndef EVCNT_DEFINES_SVH
`define EVCNT_DEFINES_SVH

// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_COMMAND 8'h04
`define OFS_COUNT_SEL 8'h08
`define OFS_COUNT_EDGE 8'h0c
`define OFS_CLEAR_SEL 8'h10
`define OFS_CLEAR_EDGE 8'h14
`define OFS_TERMINAL 8'h18
`define OFS_VALUE 8'h1c
`define OFS_CAPTURED 8'h20
`define OFS_STATE 8'h24
`define OFS_IRQ_STATUS 8'h28
`define OFS_IRQ_CLEAR 8'h2c
`define OFS_IRQ_ENABLE 8'h30

// Field positions
`define BIT_ENABLE 0
`define BIT_CLEAR_CMD 0
`define IRQ_BIT_DONE 0
`define IRQ_BIT_CLEARED 1
`define IRQ_WIDTH 2

// Reset values
`define RST_CONTROL 1'h0
`define RST_COUNT_SEL 4'h0
`define RST_EDGE 2'h0
`define RST_CLEAR_SEL 4'h0
`define RST_TERMINAL 32'hffffffff
`define RST_IRQ_ENABLE 2'h0

// Timing: microsecond tick from a 100 ns clock
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES ((`TICK_PERIOD_NS) / (`CLK_PERIOD_NS))

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** inc/evcnt_pkg.sv ***
// Purpose: Types shared by the event counter files
// Assumes: Constants live in evcnt_defines.svh
// Notes: Select codes match the register field encodings
package evcnt_pkg;

  typedef enum logic [3:0] {
    CNT_OFF = 4'h0,
    CNT_ACQ_START = 4'h1,
    CNT_ACQ_END = 4'h2,
    CNT_EXP_START = 4'h3,
    CNT_EXP_END = 4'h4,
    CNT_FRAME_START = 4'h5,
    CNT_ACCEPTED = 4'h6,
    CNT_REJECTED = 4'h7,
    CNT_LINE1 = 4'h8,
    CNT_LINE2 = 4'h9,
    CNT_LINE3 = 4'ha,
    CNT_TICK = 4'hb,
    CNT_TIMER_DONE = 4'hc
  } count_event_select_e;

  typedef enum logic [3:0] {
    CLR_CMD_ONLY = 4'h0,
    CLR_ACQ_START = 4'h1,
    CLR_ACQ_END = 4'h2,
    CLR_EXP_START = 4'h3,
    CLR_EXP_END = 4'h4,
    CLR_FRAME_TRIGGER = 4'h5,
    CLR_ACCEPTED = 4'h6,
    CLR_REJECTED = 4'h7,
    CLR_LINE1 = 4'h8,
    CLR_LINE2 = 4'h9,
    CLR_TIMER_DONE = 4'ha,
    CLR_COUNTER_DONE = 4'hb
  } clear_event_select_e;

  typedef enum logic [1:0] {
    EDGE_RISING = 2'h0,
    EDGE_FALLING = 2'h1,
    EDGE_ANY = 2'h2
  } edge_select_e;

  // Gray along wait -> active -> completed
  typedef enum logic [1:0] {
    ST_WAIT_START = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_COMPLETED = 2'h3
  } count_state_e;

endpackage

// *** rtl/line_edge_sync.sv ***
// Purpose: Bring input lines into the core clock and find their edges
// Assumes: Lines are asynchronous to the core clock
// Notes: One-cycle rise and fall pulses per settled transition
`timescale 1ns/100ps
module line_edge_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] line_in,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  // Two stages before any logic looks at the line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= line_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edges compare settled samples only, one pulse each
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;

endmodule

// *** rtl/event_counter.sv ***
// Purpose: Event counter with selectable increment and clear sources
// Assumes: Event inputs are one-cycle pulses on CORE_CLK
// Notes: Registers over AXI4-Lite; lines are asynchronous pins
//
// Contract
// - A chosen internal event adds one to the count per occurrence.
// - A chosen line adds one per transition matching the count edge.
// - The tick source adds one on each microsecond tick.
// - Count edge offers rising, falling or both edges.
// - A clear zeroes the count and waits for the start condition.
// - In command-only mode only the software command clears.
// - Clear choices cover the listed camera, timer and counter events.
// - The frame-trigger clear fires on any trigger, accepted or not.
// - A chosen line one or two clears on a matching clear edge.
// - Clear edge offers rising, falling or either edge.
// - Count-done fires when the count reaches the terminal setting.
// - Each clear captures the count held just before it.
`timescale 1ns/100ps
`include "evcnt_defines.svh"
module event_counter (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Camera event pulses
  input wire logic ACQ_START,
  input wire logic ACQ_END,
  input wire logic EXPOSURE_START,
  input wire logic EXPOSURE_END,
  input wire logic FRAME_START,
  input wire logic FRAME_TRIGGER,
  input wire logic ACCEPTED_FRAME_TRIGGER,
  input wire logic REJECTED_TRIGGER,
  input wire logic FIRST_TIMER_DONE,
  input wire logic FIRST_COUNTER_DONE,
  input wire logic START_CONDITION,
  // Input line pins
  input wire logic LINE1,
  input wire logic LINE2,
  input wire logic LINE3,
  // Results
  output logic COUNT_DONE_EVENT,
  output logic IRQ
);

  localparam int TICK_W = 4;
  localparam logic [TICK_W-1:0] TICK_LAST =
    TICK_W'(`TICK_CYCLES - 1);

  // Edge selection shared by counting and clearing
  function automatic logic edge_hit(input logic r, input logic f,
                                    input logic [1:0] sel);
    unique case (sel)
      evcnt_pkg::EDGE_RISING: edge_hit = r;
      evcnt_pkg::EDGE_FALLING: edge_hit = f;
      evcnt_pkg::EDGE_ANY: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  logic [2:0] line_rise;
  logic [2:0] line_fall;

  logic enable_ff;
  logic [3:0] count_sel_ff;
  logic [1:0] count_edge_ff;
  logic [3:0] clear_sel_ff;
  logic [1:0] clear_edge_ff;
  logic [31:0] terminal_ff;
  logic [31:0] count_ff;
  logic [31:0] captured_ff;
  logic [`IRQ_WIDTH-1:0] irq_status_ff;
  logic [`IRQ_WIDTH-1:0] irq_enable_ff;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  logic done_ff;
  evcnt_pkg::count_state_e state_ff;
  evcnt_pkg::count_state_e nxt_state;

  logic aw_held_ff;
  logic [7:0] awaddr_ff;
  logic w_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic wr_fire;
  logic rd_fire;
  logic clear_cmd;
  logic inc_event;
  logic clear_event;
  logic hw_clear;
  logic clear_now;
  logic reach;

  line_edge_sync #(
    .WIDTH(3)
  ) u_lines (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .line_in({LINE3, LINE2, LINE1}),
    .rise(line_rise),
    .fall(line_fall)
  );

  // Microsecond tick divider, free running
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
      tick_ff <= 1'b0;
    end
  end

  // Increment source multiplexer
  always_comb begin
    unique case (count_sel_ff)
      evcnt_pkg::CNT_ACQ_START: inc_event = ACQ_START;
      evcnt_pkg::CNT_ACQ_END: inc_event = ACQ_END;
      evcnt_pkg::CNT_EXP_START: inc_event = EXPOSURE_START;
      evcnt_pkg::CNT_EXP_END: inc_event = EXPOSURE_END;
      evcnt_pkg::CNT_FRAME_START: inc_event = FRAME_START;
      evcnt_pkg::CNT_ACCEPTED: inc_event = ACCEPTED_FRAME_TRIGGER;
      evcnt_pkg::CNT_REJECTED: inc_event = REJECTED_TRIGGER;
      evcnt_pkg::CNT_LINE1:
        inc_event = edge_hit(line_rise[0], line_fall[0],
                             count_edge_ff);
      evcnt_pkg::CNT_LINE2:
        inc_event = edge_hit(line_rise[1], line_fall[1],
                             count_edge_ff);
      evcnt_pkg::CNT_LINE3:
        inc_event = edge_hit(line_rise[2], line_fall[2],
                             count_edge_ff);
      evcnt_pkg::CNT_TICK: inc_event = tick_ff;
      evcnt_pkg::CNT_TIMER_DONE: inc_event = FIRST_TIMER_DONE;
      default: inc_event = 1'b0; // Off and unused codes
    endcase
  end

  // Clear source multiplexer; command-only selects no hardware source
  always_comb begin
    unique case (clear_sel_ff)
      evcnt_pkg::CLR_ACQ_START: clear_event = ACQ_START;
      evcnt_pkg::CLR_ACQ_END: clear_event = ACQ_END;
      evcnt_pkg::CLR_EXP_START: clear_event = EXPOSURE_START;
      evcnt_pkg::CLR_EXP_END: clear_event = EXPOSURE_END;
      evcnt_pkg::CLR_FRAME_TRIGGER: clear_event = FRAME_TRIGGER;
      evcnt_pkg::CLR_ACCEPTED:
        clear_event = ACCEPTED_FRAME_TRIGGER;
      evcnt_pkg::CLR_REJECTED: clear_event = REJECTED_TRIGGER;
      evcnt_pkg::CLR_LINE1:
        clear_event = edge_hit(line_rise[0], line_fall[0],
                               clear_edge_ff);
      evcnt_pkg::CLR_LINE2:
        clear_event = edge_hit(line_rise[1], line_fall[1],
                               clear_edge_ff);
      evcnt_pkg::CLR_TIMER_DONE: clear_event = FIRST_TIMER_DONE;
      evcnt_pkg::CLR_COUNTER_DONE:
        clear_event = FIRST_COUNTER_DONE;
      default: clear_event = 1'b0;
    endcase
  end

  // Clear wins over a same-cycle increment
  assign hw_clear = clear_event;
  assign clear_now = hw_clear | clear_cmd;
  assign reach = (state_ff == evcnt_pkg::ST_ACTIVE) && inc_event &&
                 (count_ff + 32'h1 == terminal_ff);

  // Counter state sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      evcnt_pkg::ST_WAIT_START: begin
        if (enable_ff && START_CONDITION && !clear_now) begin
          nxt_state = evcnt_pkg::ST_ACTIVE;
        end
      end
      evcnt_pkg::ST_ACTIVE: begin
        if (reach) begin
          nxt_state = evcnt_pkg::ST_COMPLETED;
        end
      end
      evcnt_pkg::ST_COMPLETED: nxt_state = state_ff;
      default: nxt_state = evcnt_pkg::ST_WAIT_START;
    endcase
    if (clear_now || !enable_ff) begin
      nxt_state = evcnt_pkg::ST_WAIT_START;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff <= evcnt_pkg::ST_WAIT_START;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Count value and capture on clear
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_ff <= '0;
      captured_ff <= '0;
    end else if (clear_now) begin
      captured_ff <= count_ff;
      count_ff <= '0;
    end else if (state_ff == evcnt_pkg::ST_ACTIVE && inc_event) begin
      count_ff <= count_ff + 32'h1;
    end
  end

  // Done pulse, one cycle after the terminal increment
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= reach && !clear_now;
    end
  end

  assign COUNT_DONE_EVENT = done_ff;

  // Write channel: address and data accepted in either order
  assign S_AXI_AWREADY = !aw_held_ff && !bvalid_ff;
  assign S_AXI_WREADY = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
      w_held_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      unique case (awaddr_ff)
        `OFS_CONTROL, `OFS_COMMAND, `OFS_COUNT_SEL, `OFS_COUNT_EDGE,
        `OFS_CLEAR_SEL, `OFS_CLEAR_EDGE, `OFS_TERMINAL,
        `OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE: bresp_ff <= `RESP_OKAY;
        default: bresp_ff <= `RESP_SLVERR;
      endcase
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;

  // Software clear command is a pulse, not stored
  assign clear_cmd = wr_fire && (awaddr_ff == `OFS_COMMAND) &&
                     wstrb_ff[0] && wdata_ff[`BIT_CLEAR_CMD];

  // Configuration registers
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      enable_ff <= `RST_CONTROL;
      count_sel_ff <= `RST_COUNT_SEL;
      count_edge_ff <= `RST_EDGE;
      clear_sel_ff <= `RST_CLEAR_SEL;
      clear_edge_ff <= `RST_EDGE;
      terminal_ff <= `RST_TERMINAL;
      irq_enable_ff <= `RST_IRQ_ENABLE;
    end else if (wr_fire && wstrb_ff[0]) begin
      unique case (awaddr_ff)
        `OFS_CONTROL: enable_ff <= wdata_ff[`BIT_ENABLE];
        `OFS_COUNT_SEL: count_sel_ff <= wdata_ff[3:0];
        `OFS_COUNT_EDGE: count_edge_ff <= wdata_ff[1:0];
        `OFS_CLEAR_SEL: clear_sel_ff <= wdata_ff[3:0];
        `OFS_CLEAR_EDGE: clear_edge_ff <= wdata_ff[1:0];
        `OFS_TERMINAL:
          terminal_ff <= merge(terminal_ff, wdata_ff, wstrb_ff);
        `OFS_IRQ_ENABLE:
          irq_enable_ff <= wdata_ff[`IRQ_WIDTH-1:0];
        default: enable_ff <= enable_ff;
      endcase
    end else if (wr_fire && awaddr_ff == `OFS_TERMINAL) begin
      terminal_ff <= merge(terminal_ff, wdata_ff, wstrb_ff);
    end
  end

  // Sticky interrupt status; a new event beats a same-cycle clear
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status_ff <= '0;
    end else begin
      if (wr_fire && awaddr_ff == `OFS_IRQ_CLEAR && wstrb_ff[0]) begin
        irq_status_ff <= (irq_status_ff &
                          ~wdata_ff[`IRQ_WIDTH-1:0]) |
                         {clear_now, done_ff};
      end else begin
        irq_status_ff <= irq_status_ff | {clear_now, done_ff};
      end
    end
  end

  assign IRQ = |(irq_status_ff & irq_enable_ff);

  // Read channel, one cycle to answer
  assign S_AXI_ARREADY = !rvalid_ff;
  assign rd_fire = S_AXI_ARVALID && !rvalid_ff;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `OFS_CONTROL: rdata_ff <= {31'h0, enable_ff};
        `OFS_COMMAND: rdata_ff <= '0; // Write-only
        `OFS_COUNT_SEL: rdata_ff <= {28'h0, count_sel_ff};
        `OFS_COUNT_EDGE: rdata_ff <= {30'h0, count_edge_ff};
        `OFS_CLEAR_SEL: rdata_ff <= {28'h0, clear_sel_ff};
        `OFS_CLEAR_EDGE: rdata_ff <= {30'h0, clear_edge_ff};
        `OFS_TERMINAL: rdata_ff <= terminal_ff;
        `OFS_VALUE: rdata_ff <= count_ff;
        `OFS_CAPTURED: rdata_ff <= captured_ff;
        `OFS_STATE: rdata_ff <= {30'h0, state_ff};
        `OFS_IRQ_STATUS: rdata_ff <= {30'h0, irq_status_ff};
        `OFS_IRQ_CLEAR: rdata_ff <= '0; // Write-only
        `OFS_IRQ_ENABLE: rdata_ff <= {30'h0, irq_enable_ff};
        default: begin
          rdata_ff <= '0;
          rresp_ff <= `RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

endmodule

// *** dv/event_counter_monitor.sv ***
// Purpose: Port-level checks for the event counter
// Assumes: One clock domain, reset active high
// Notes: Bound into every event_counter instance
`timescale 1ns/100ps
module event_counter_monitor (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic START_CONDITION,
  input wire logic COUNT_DONE_EVENT
);
  logic seen_start_ff;
  default clocking mcb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Done is only legal once a start has been seen since reset
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      seen_start_ff <= 1'b0;
    end else if (START_CONDITION) begin
      seen_start_ff <= 1'b1;
    end
  end
  // Write address and data taken at one edge
  sequence both_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence b_answer;
    ##[1:2] S_AXI_BVALID;
  endsequence
  write_answer_a: assert property (both_taken |-> b_answer)
    else $error("write response late");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID) else $error("read data not next cycle");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  b_blocks_a: assert property (S_AXI_BVALID
    |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write accepted early");
  r_blocks_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted early");
  done_pulse_a: assert property (
    COUNT_DONE_EVENT |=> !COUNT_DONE_EVENT)
    else $error("done longer than one cycle");
  done_start_a: assert property (COUNT_DONE_EVENT |-> seen_start_ff
    && !$past(START_CONDITION)) else $error("done without start");
endmodule

bind event_counter event_counter_monitor u_mon (
  .CORE_CLK, .SYS_RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .S_AXI_RREADY, .START_CONDITION, .COUNT_DONE_EVENT);

// *** dv/camera_events_model.sv ***
// Purpose: Camera trigger logic and input lines facing the counter
// Assumes: Event bits 0..9 in port order, bit 10 is the start
// Notes: Lines are held well past the two-cycle minimum
`timescale 1ns/100ps
module camera_events_model (
  input wire logic clk,
  output logic [10:0] ev,
  output logic [2:0] lines
);
  // Quiet until the bench asks
  initial begin
    ev = 11'h000;
    lines = 3'h0;
  end
  // One-cycle pulse, launched just after an edge; an accepted or
  // rejected trigger is a frame trigger as well
  task automatic fire(input int idx);
    logic [10:0] mask;
    mask = 11'h1 << idx;
    if (idx == 6 || idx == 7) mask[5] = 1'b1;
    @(posedge clk);
    ev <= ev | mask;
    @(posedge clk);
    ev <= ev & ~mask;
  endtask
  // Slow line change; waits for sync and edge logic to land
  task automatic set_line(input int idx, input logic val);
    @(posedge clk);
    lines[idx] <= val;
    repeat (6) @(posedge clk);
  endtask
endmodule

// *** dv/event_counter_tb.sv ***
// Purpose: Self-checking bench for the event counter
// Assumes: Registers reached over AXI4-Lite, 100 ns clock
// Notes: Count value read back to judge every source
`timescale 1ns/100ps
`include "evcnt_defines.svh"
module event_counter_tb;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, done, irq;
  logic [1:0] bresp, rresp;
  logic [10:0] ev;
  logic [2:0] lines;
  int fails = 0, n_checks = 0, n_done = 0;
  event_counter u_dut (.CORE_CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ACQ_START(ev[0]),
    .ACQ_END(ev[1]), .EXPOSURE_START(ev[2]), .EXPOSURE_END(ev[3]),
    .FRAME_START(ev[4]), .FRAME_TRIGGER(ev[5]),
    .ACCEPTED_FRAME_TRIGGER(ev[6]), .REJECTED_TRIGGER(ev[7]),
    .FIRST_TIMER_DONE(ev[8]), .FIRST_COUNTER_DONE(ev[9]),
    .START_CONDITION(ev[10]), .LINE1(lines[0]), .LINE2(lines[1]),
    .LINE3(lines[2]), .COUNT_DONE_EVENT(done), .IRQ(irq));
  camera_events_model u_cam (.clk(clk), .ev(ev), .lines(lines));
  // Clock and done-pulse tally
  always #50 clk = ~clk;
  always @(posedge clk) if (done === 1'b1) n_done++;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus write; each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    wstrb <= s;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) begin fails++; give_verdict(); end
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  // Bus read; the data stands on rdata until the next read
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) begin fails++; give_verdict(); end
  endtask
  // Bus read with data and response comparison
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = `RESP_OKAY);
    rd(a);
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  // Software clear, then a start; events in the start cycle are skipped
  task automatic rearm();
    wr(`OFS_COMMAND, 32'h1);
    u_cam.fire(10);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    rdc(`OFS_CONTROL, 32'h0);
    rdc(`OFS_COUNT_SEL, 32'h0);
    rdc(`OFS_TERMINAL, 32'hffffffff);
    // Byte strobes on the terminal setting, then back to all ones
    wr(`OFS_TERMINAL, 32'h12345678, `RESP_OKAY, 4'hd);
    wr(`OFS_TERMINAL, 32'h0000ab00, `RESP_OKAY, 4'h2);
    rdc(`OFS_TERMINAL, 32'h1234ab78);
    wr(`OFS_TERMINAL, 32'hffffffff);
    rdc(`OFS_IRQ_ENABLE, 32'h0);
    rdc(`OFS_STATE, 32'h0);
    rdc(8'hc0, 32'h0, `RESP_SLVERR);
    wr(8'hc0, 32'h1, `RESP_SLVERR);
    wr(`OFS_VALUE, 32'h5, `RESP_SLVERR);
  endtask
  // Each internal increment source, with an unselected decoy
  task automatic t_count_events();
    int code[8] = '{1, 2, 3, 4, 5, 6, 7, 12};
    int evx[8] = '{0, 1, 2, 3, 4, 6, 7, 8};
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_COUNT_SEL, code[i]);
      rearm();
      repeat (3) u_cam.fire(evx[i]);
      u_cam.fire(5);
      rdc(`OFS_VALUE, 32'h3);
    end
  endtask
  // Every line with every count edge code, unused code 3 included
  task automatic t_count_lines();
    for (int k = 0; k < 3; k++) for (int e = 0; e < 4; e++) begin
      wr(`OFS_COUNT_SEL, 8 + k);
      wr(`OFS_COUNT_EDGE, e);
      rearm();
      u_cam.set_line(k, 1'b1);
      u_cam.set_line(k, 1'b0);
      rdc(`OFS_VALUE,
          (e == 2) ? 32'h2 : (e == 3) ? 32'h0 : 32'h1);
    end
  endtask
  // Microsecond tick: reads 103 cycles apart see 10 or 11 ticks
  task automatic t_tick();
    logic [31:0] v0;
    wr(`OFS_COUNT_SEL, 32'hb);
    rearm();
    rdc(`OFS_STATE, 32'h1);
    rd(`OFS_VALUE);
    v0 = rdata;
    repeat (100) @(posedge clk);
    rd(`OFS_VALUE);
    chk("tick", 32'h1, {31'h0, (rdata - v0) inside {10, 11}});
  endtask
  // Command-only clear ignores all events; then each event clear.
  // A rejected trigger drives the frame-trigger choice.
  task automatic t_clear_events();
    int code[9] = '{1, 2, 3, 4, 5, 6, 7, 10, 11};
    int evx[9] = '{0, 1, 2, 3, 7, 6, 7, 8, 9};
    int dcy[9] = '{7, 7, 7, 7, 1, 7, 6, 7, 7};
    wr(`OFS_COUNT_SEL, 32'h5);
    wr(`OFS_CLEAR_SEL, 32'h0);
    rearm();
    repeat (2) u_cam.fire(4);
    for (int j = 0; j < 10; j++) if (j != 4) u_cam.fire(j);
    rdc(`OFS_VALUE, 32'h2);
    for (int i = 0; i < 9; i++) begin
      wr(`OFS_CLEAR_SEL, code[i]);
      rearm();
      repeat (2) u_cam.fire(4);
      u_cam.fire(dcy[i]);
      u_cam.fire(evx[i]);
      rdc(`OFS_VALUE, 32'h0);
      rdc(`OFS_CAPTURED, 32'h2);
      u_cam.fire(4);
      rdc(`OFS_VALUE, 32'h0);
      rdc(`OFS_STATE, 32'h0);
    end
  endtask
  // Line clears with each clear edge
  task automatic t_clear_lines();
    for (int l = 0; l < 2; l++) for (int e = 0; e < 3; e++) begin
      wr(`OFS_CLEAR_SEL, 8 + l);
      wr(`OFS_CLEAR_EDGE, e);
      rearm();
      repeat (2) u_cam.fire(4);
      u_cam.set_line(l, 1'b1);
      rdc(`OFS_VALUE, (e == 1) ? 32'h2 : 32'h0);
      u_cam.set_line(l, 1'b0);
      rdc(`OFS_VALUE, 32'h0);
      rdc(`OFS_CAPTURED, (e == 2) ? 32'h0 : 32'h2);
    end
  endtask
  // Terminal count, done pulse, interrupt raise, mask and clear
  task automatic t_done();
    int d0;
    wr(`OFS_CLEAR_SEL, 32'h0);
    wr(`OFS_TERMINAL, 32'h3);
    wr(`OFS_IRQ_ENABLE, 32'h1);
    rearm();
    d0 = n_done;
    repeat (3) u_cam.fire(4);
    repeat (3) @(posedge clk);
    chk("done", 32'h1, n_done - d0);
    rdc(`OFS_STATE, 32'h3);
    rdc(`OFS_IRQ_STATUS, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    u_cam.fire(4);
    rdc(`OFS_VALUE, 32'h3);
    wr(`OFS_IRQ_CLEAR, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_ENABLE, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_ENABLE, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_CLEAR, 32'h3);
    rdc(`OFS_IRQ_STATUS, 32'h0);
    rearm();
    rdc(`OFS_CAPTURED, 32'h3);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    wr(`OFS_CONTROL, 32'h1);
    t_count_events();
    t_count_lines();
    t_tick();
    t_clear_events();
    t_clear_lines();
    t_done();
    give_verdict();
  end
endmodule
